// ===== rtl/lics_pkg.sv
package lics_pkg;

    // Timing clock is 40 MHz.
    localparam int unsigned CLK_HZ           = 40000000;
    localparam int unsigned QUALIFY_TIME_MS  = 30;
    localparam int unsigned QUALIFY_CYCLES   = CLK_HZ / 1000 * QUALIFY_TIME_MS;
    localparam int unsigned FAULT_PULSE_HZ   = 2;
    localparam int unsigned FAULT_HALF_CYCLES = CLK_HZ / (2 * FAULT_PULSE_HZ);
    localparam int unsigned CNT_W            = 25;
    localparam int unsigned ILIM_W           = 8;
    localparam logic [7:0]  RAMP_STEP_CYCLES = 8'hff;
    localparam logic [7:0]  ILIM_MAX         = 8'hff;
    localparam logic [7:0]  ILIM_LOW_SEL     = 8'h40;

    typedef enum logic [1:0] {
        LICS_MODE_HIZ,
        LICS_MODE_CHARGE,
        LICS_MODE_BOOST
    } lics_mode_type;

    typedef enum logic [2:0] {
        LICS_ST_IDLE,
        LICS_ST_QUALIFY,
        LICS_ST_PRECHARGE,
        LICS_ST_SWITCHING,
        LICS_ST_DONE,
        LICS_ST_FAULT
    } lics_state_type;

    // Comparator outputs from the analog side.
    typedef struct packed {
        logic above_uvlo;
        logic above_ovp;
        logic below_ovp_hyst;
        logic below_sleep;
        logic below_precharge;
        logic below_recharge;
        logic at_float;
        logic below_end_current;
        logic at_special_floor;
        logic at_foldback;
        logic above_shutdown;
        logic below_cool;
        logic low_side_negative;
    } lics_sense_type;

    // Power stage controls toward the analog side.
    typedef struct packed {
        logic          blocking_switch_on;
        logic          high_side_enable;
        logic          high_side_body_switch;
        logic          low_side_enable;
        logic          linear_source_on;
        logic          switching_enable;
        logic          boost_enable;
        logic          validation_load_on;
        logic          current_foldback;
        logic [ILIM_W-1:0] charge_current_cmd;
        logic [ILIM_W-1:0] input_current_limit;
    } lics_drive_type;

endpackage

// ===== rtl/lics_sequencer.sv
`timescale 1ns/1ps
module lics_sequencer (
    input  wire logic                     core_clk_i,
    input  wire logic                     rst_n_i,
    input  wire logic                     boost_request_pin_i,
    input  wire logic                     charge_inhibit_pin_i,
    input  wire logic                     input_limit_sel_i,
    input  wire lics_pkg::lics_sense_type sense_i,
    output logic                          stat_oe_o,
    output logic                          stat_o,
    output lics_pkg::lics_drive_type      drive_o,
    output lics_pkg::lics_mode_type       mode_o,
    output lics_pkg::lics_state_type      state_o
);

    localparam int unsigned SYNC_W = $bits(lics_pkg::lics_sense_type) + 3;

    typedef struct packed {
        logic [SYNC_W-1:0]                 sync1;
        logic [SYNC_W-1:0]                 sync2;
        lics_pkg::lics_state_type          state;
        lics_pkg::lics_mode_type           mode;
        logic [lics_pkg::CNT_W-1:0]        qual_cnt;
        logic [lics_pkg::CNT_W-1:0]        blink_cnt;
        logic                              blink;
        logic [7:0]                        ramp_cnt;
        logic [lics_pkg::ILIM_W-1:0]       cur_cmd;
        logic                              inhibit_prev;
        logic                              uvlo_prev;
        logic                              ovp_latched;
        logic                              thermal_latched;
        logic                              stat_oe;
        logic                              stat;
        lics_pkg::lics_drive_type          drive;
    } lics_regs_type;

    lics_regs_type r;
    lics_regs_type nxt;

    lics_pkg::lics_sense_type s;
    logic boost_req;
    logic inhibit;
    logic limit_sel;
    logic in_range;
    logic fault;
    logic restart;
    logic [lics_pkg::ILIM_W-1:0] in_lim;

    // Every pin crosses two flops; only the second stage is read.
    assign {s, boost_req, inhibit, limit_sel} = r.sync2;

    always_comb begin
        nxt       = r;
        nxt.sync1 = {sense_i, boost_request_pin_i, charge_inhibit_pin_i, input_limit_sel_i};
        nxt.sync2 = r.sync1;
        // Both edge detectors reset to the idle level of their inputs, so reset brings no false edge.
        nxt.inhibit_prev = inhibit;
        nxt.uvlo_prev    = s.above_uvlo;

        if (limit_sel) begin
            in_lim = lics_pkg::ILIM_MAX;
        end else begin
            in_lim = lics_pkg::ILIM_LOW_SEL;
        end

        in_range = 1'b0;
        if (s.above_uvlo && !s.above_ovp && !r.ovp_latched) begin
            in_range = 1'b1;
        end

        // The latch holds the fault through the hysteresis band so the blocking switch cannot chatter.
        if (s.above_ovp) begin
            nxt.ovp_latched = 1'b1;
        end else if (s.below_ovp_hyst) begin
            nxt.ovp_latched = 1'b0;
        end

        // Release waits for the die to cool, not merely to fall below the trip level.
        if (s.above_shutdown) begin
            nxt.thermal_latched = 1'b1;
        end else if (s.below_cool) begin
            nxt.thermal_latched = 1'b0;
        end

        fault = 1'b0;
        if (r.ovp_latched || s.above_ovp) begin
            fault = 1'b1;
        end

        if (r.thermal_latched || s.above_shutdown) begin
            fault = 1'b1;
        end

        if (s.below_sleep && s.above_uvlo) begin
            fault = 1'b1;
        end

        if (!s.above_uvlo) begin
            fault = 1'b1;
        end

        // Restart triggers; a rising supply with a low battery is caught as a new qualify.
        restart = 1'b0;
        if (inhibit != r.inhibit_prev) begin
            restart = 1'b1;
        end

        if (s.above_uvlo && !r.uvlo_prev && s.below_precharge) begin
            restart = 1'b1;
        end

        // A boost request wins over charging, even with a valid supply present.
        if (boost_req) begin
            nxt.mode = lics_pkg::LICS_MODE_BOOST;
        end else if (!s.above_uvlo) begin
            nxt.mode = lics_pkg::LICS_MODE_HIZ;
        end else if (inhibit) begin
            nxt.mode = lics_pkg::LICS_MODE_HIZ;
        end else begin
            nxt.mode = lics_pkg::LICS_MODE_CHARGE;
        end

        // The qualify count restarts on any excursion, so only an unbroken window counts.
        if (r.state != lics_pkg::LICS_ST_QUALIFY) begin
            nxt.qual_cnt = '0;
        end else if (!in_range) begin
            nxt.qual_cnt = '0;
        end else if (r.qual_cnt != lics_pkg::CNT_W'(lics_pkg::QUALIFY_CYCLES)) begin
            nxt.qual_cnt = r.qual_cnt + 1'b1;
        end

        // Faults are checked before precharge and switching move on; qualify checks after mode, idle and done never.
        unique case (r.state)
            lics_pkg::LICS_ST_IDLE: begin
                if (nxt.mode == lics_pkg::LICS_MODE_CHARGE) begin
                    nxt.state = lics_pkg::LICS_ST_QUALIFY;
                end
            end

            lics_pkg::LICS_ST_QUALIFY: begin
                if (r.mode != lics_pkg::LICS_MODE_CHARGE) begin
                    nxt.state = lics_pkg::LICS_ST_IDLE;
                end else if (fault) begin
                    nxt.state = lics_pkg::LICS_ST_FAULT;
                end else if (r.qual_cnt == lics_pkg::CNT_W'(lics_pkg::QUALIFY_CYCLES) && !fault) begin
                    nxt.state = s.below_precharge ? lics_pkg::LICS_ST_PRECHARGE
                                                  : lics_pkg::LICS_ST_SWITCHING;
                end
            end

            lics_pkg::LICS_ST_PRECHARGE: begin
                if (fault) begin
                    nxt.state = lics_pkg::LICS_ST_FAULT;
                end else if (!s.below_precharge) begin
                    nxt.state = lics_pkg::LICS_ST_SWITCHING;
                end
            end

            lics_pkg::LICS_ST_SWITCHING: begin
                if (fault) begin
                    nxt.state = lics_pkg::LICS_ST_FAULT;
                end else if (s.at_float && s.below_end_current) begin
                    nxt.state = lics_pkg::LICS_ST_DONE;
                end
            end

            lics_pkg::LICS_ST_DONE: begin
                if (s.below_recharge || restart) begin
                    nxt.state = lics_pkg::LICS_ST_QUALIFY;
                end else if (r.mode != lics_pkg::LICS_MODE_CHARGE) begin
                    nxt.state = lics_pkg::LICS_ST_IDLE;
                end
            end

            lics_pkg::LICS_ST_FAULT: begin
                // Leaving through qualify gives the 30 ms recovery after any fault.
                if (!fault) begin
                    nxt.state = lics_pkg::LICS_ST_QUALIFY;
                end
            end
            default: begin
                nxt.state = lics_pkg::LICS_ST_IDLE;
            end
        endcase

        // A phase in progress falls back to idle once charge mode is gone; a fault keeps its own exit.
        if (r.mode != lics_pkg::LICS_MODE_CHARGE) begin
            if (r.state != lics_pkg::LICS_ST_IDLE && r.state != lics_pkg::LICS_ST_FAULT) begin
                nxt.state = lics_pkg::LICS_ST_IDLE;
            end
        end
        // A restart goes through qualification again, so supply validation always repeats.
        if (restart) begin
            if (r.state != lics_pkg::LICS_ST_IDLE && r.state != lics_pkg::LICS_ST_FAULT) begin
                nxt.state = lics_pkg::LICS_ST_QUALIFY;
            end
        end

        // Slow current ramp; held when the supply sags to the special floor, stepped down while the die is hot.
        if (r.state != lics_pkg::LICS_ST_SWITCHING) begin
            nxt.cur_cmd  = '0;
            nxt.ramp_cnt = '0;
        end else if (s.at_foldback) begin
            nxt.ramp_cnt = '0;
            if (r.cur_cmd != '0) begin
                nxt.cur_cmd = r.cur_cmd - 1'b1;
            end
        end else if (r.ramp_cnt != lics_pkg::RAMP_STEP_CYCLES) begin
            nxt.ramp_cnt = r.ramp_cnt + 1'b1;
        end else begin
            nxt.ramp_cnt = '0;
            if (s.at_special_floor) begin
                nxt.cur_cmd = r.cur_cmd;
            end else if (r.cur_cmd < in_lim) begin
                nxt.cur_cmd = r.cur_cmd + 1'b1;
            end
        end

        if (!fault) begin
            nxt.blink_cnt = '0;
            nxt.blink     = 1'b0;
        end else if (r.blink_cnt == lics_pkg::CNT_W'(lics_pkg::FAULT_HALF_CYCLES - 1)) begin
            nxt.blink_cnt = '0;
            nxt.blink     = !r.blink;
        end else begin
            nxt.blink_cnt = r.blink_cnt + 1'b1;
        end

        // Open-drain status: enable high means pulling low.
        // A fault outside charge mode leaves the pin to the phase.
        if (fault && r.mode == lics_pkg::LICS_MODE_CHARGE) begin
            nxt.stat_oe = r.blink;
        end else begin
            unique case (r.state)
                lics_pkg::LICS_ST_PRECHARGE, lics_pkg::LICS_ST_SWITCHING: begin
                    nxt.stat_oe = 1'b1;
                end
                default: begin
                    nxt.stat_oe = 1'b0;
                end
            endcase
        end
        nxt.stat = 1'b0;

        // The blocking switch opens on overvoltage and stays open until the fault clears.
        if (s.above_ovp || r.ovp_latched || r.mode == lics_pkg::LICS_MODE_HIZ) begin
            nxt.drive.blocking_switch_on = 1'b0;
        end else begin
            nxt.drive.blocking_switch_on = 1'b1;
        end

        if (s.below_sleep && s.above_uvlo) begin
            nxt.drive.high_side_body_switch = 1'b1;
        end else begin
            nxt.drive.high_side_body_switch = 1'b0;
        end

        if (r.state == lics_pkg::LICS_ST_PRECHARGE) begin
            nxt.drive.linear_source_on = 1'b1;
        end else begin
            nxt.drive.linear_source_on = 1'b0;
        end

        // Switching stops in the cycle a fault is seen, on the same edge as the state register enters fault.
        if (r.state == lics_pkg::LICS_ST_SWITCHING && !fault) begin
            nxt.drive.switching_enable = 1'b1;
            nxt.drive.high_side_enable = 1'b1;
        end else begin
            nxt.drive.switching_enable = 1'b0;
            nxt.drive.high_side_enable = 1'b0;
        end

        // Reverse current out of the battery is cut at once, whatever the phase.
        if (r.state == lics_pkg::LICS_ST_SWITCHING && !fault && !s.low_side_negative) begin
            nxt.drive.low_side_enable = 1'b1;
        end else begin
            nxt.drive.low_side_enable = 1'b0;
        end

        if (r.mode == lics_pkg::LICS_MODE_BOOST) begin
            nxt.drive.boost_enable = 1'b1;
        end else begin
            nxt.drive.boost_enable = 1'b0;
        end

        if (r.state == lics_pkg::LICS_ST_QUALIFY && s.above_uvlo) begin
            nxt.drive.validation_load_on = 1'b1;
        end else begin
            nxt.drive.validation_load_on = 1'b0;
        end

        // Foldback is passed to the analog loop as well as stepping the ramp down.
        if (s.at_foldback) begin
            nxt.drive.current_foldback = 1'b1;
        end else begin
            nxt.drive.current_foldback = 1'b0;
        end

        nxt.drive.charge_current_cmd  = r.cur_cmd;
        nxt.drive.input_current_limit = in_lim;
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end

    // Outputs come straight from the register copy, so they never glitch.
    assign stat_oe_o = r.stat_oe;
    assign stat_o    = r.stat;
    assign drive_o   = r.drive;
    assign mode_o    = r.mode;
    assign state_o   = r.state;

endmodule

// ===== verif/lics_analog_model.sv
`timescale 1ns/1ps
module lics_analog_model #(
    parameter logic [15:0] UVLO_MV  = 16'h10cc,
    parameter logic [15:0] OVP_MV   = 16'h1770,
    parameter logic [15:0] HYST_MV  = 16'h00c8,
    parameter logic [15:0] SLEEP_MV = 16'h0028,
    parameter logic [15:0] SHORT_MV = 16'h07d0,
    parameter logic [15:0] FLOAT_MV = 16'h1068,
    parameter logic [7:0]  HOT_C    = 8'h91,
    parameter logic [7:0]  FOLD_C   = 8'h78
) (
    input  wire logic [15:0]              vbus_mv_i,
    input  wire logic [15:0]              vbat_mv_i,
    input  wire logic [7:0]               die_c_i,
    input  wire logic                     neg_current_i,
    input  wire lics_pkg::lics_drive_type drive_i,
    output lics_pkg::lics_sense_type      sense_o
);
    always_comb begin
        sense_o = '0;
        sense_o.above_uvlo = vbus_mv_i > UVLO_MV;
        sense_o.above_ovp = vbus_mv_i > OVP_MV;
        sense_o.below_ovp_hyst = vbus_mv_i < OVP_MV - HYST_MV;
        sense_o.below_sleep = vbus_mv_i < vbat_mv_i + SLEEP_MV;
        sense_o.below_precharge = vbat_mv_i < SHORT_MV;
        sense_o.below_recharge = vbat_mv_i < FLOAT_MV - 16'h0064;
        sense_o.at_float = vbat_mv_i >= FLOAT_MV;
        sense_o.at_foldback = die_c_i >= FOLD_C;
        sense_o.above_shutdown = die_c_i >= HOT_C;
        sense_o.below_cool = die_c_i <= FOLD_C;
        // Reverse current exists only while the low side really conducts.
        sense_o.low_side_negative = neg_current_i && drive_i.low_side_enable;
    end
endmodule

// ===== verif/lics_seq_props.sv
`timescale 1ns/1ps
module lics_seq_props (
    input wire logic                     core_clk_i,
    input wire logic                     rst_n_i,
    input wire lics_pkg::lics_sense_type sense_i,
    input wire logic                     stat_oe_o,
    input wire lics_pkg::lics_drive_type drive_o,
    input wire lics_pkg::lics_mode_type  mode_o,
    input wire lics_pkg::lics_state_type state_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence enter_charge;
        !(state_o inside {lics_pkg::LICS_ST_PRECHARGE, lics_pkg::LICS_ST_SWITCHING})
        ##1 state_o inside {lics_pkg::LICS_ST_PRECHARGE, lics_pkg::LICS_ST_SWITCHING};
    endsequence
    hiz_paths_off_a: assert property ((mode_o == lics_pkg::LICS_MODE_HIZ)[*3]
        |-> !drive_o.switching_enable && !drive_o.linear_source_on && !drive_o.boost_enable) else $error("path on");
    stat_idle_open_a: assert property ((state_o == lics_pkg::LICS_ST_IDLE)[*2] |-> !stat_oe_o)
        else $error("status low when idle");
    qualify_load_a: assert property ((state_o == lics_pkg::LICS_ST_QUALIFY)[*2]
        |-> drive_o.validation_load_on) else $error("no validation load");
    ovp_blocks_a: assert property (sense_i.above_ovp[*6] |-> !drive_o.blocking_switch_on)
        else $error("blocking switch on");
    ovp_fault_a: assert property ((sense_i.above_ovp && mode_o == lics_pkg::LICS_MODE_CHARGE)[*6]
        |-> state_o == lics_pkg::LICS_ST_FAULT) else $error("no fault");
    low_side_off_a: assert property (sense_i.low_side_negative[*6] |-> !drive_o.low_side_enable)
        else $error("low side on");
    fault_holds_a: assert property (state_o == lics_pkg::LICS_ST_FAULT
        |=> !(state_o inside {lics_pkg::LICS_ST_PRECHARGE, lics_pkg::LICS_ST_SWITCHING, lics_pkg::LICS_ST_DONE}))
        else $error("phase advanced in fault");
    via_qualify_a: assert property (enter_charge |-> $past(state_o, 2) == lics_pkg::LICS_ST_QUALIFY)
        else $error("charge without qualify");
    ramp_step_a: assert property (drive_o.charge_current_cmd > $past(drive_o.charge_current_cmd)
        |-> drive_o.charge_current_cmd == $past(drive_o.charge_current_cmd) + 8'h01) else $error("ramp jump");
endmodule
bind lics_sequencer lics_seq_props u_props (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .sense_i(sense_i),
    .stat_oe_o(stat_oe_o), .drive_o(drive_o), .mode_o(mode_o), .state_o(state_o));

// ===== verif/test_li_ion_charge_sequencer.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin errors++; \
    $display("mismatch at %0t: got %0h expected %0h", $time, got, exp); end end
module test_li_ion_charge_sequencer;
    logic                     core_clk_i;
    logic                     rst_n_i;
    logic                     boost_pin;
    logic                     limit_sel;
    logic [15:0]              vbus;
    logic [15:0]              vbat;
    logic [7:0]               die;
    lics_pkg::lics_sense_type sense;
    lics_pkg::lics_drive_type drive;
    lics_pkg::lics_mode_type  mode;
    lics_pkg::lics_state_type state;
    logic                     stat_oe;
    int                       errors = 0;
    int                       check_count = 0;
    lics_analog_model model (.vbus_mv_i(vbus), .vbat_mv_i(vbat), .die_c_i(die), .neg_current_i(1'b0),
        .drive_i(drive), .sense_o(sense));
    lics_sequencer uut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .boost_request_pin_i(boost_pin),
        .charge_inhibit_pin_i(1'b0), .input_limit_sel_i(limit_sel), .sense_i(sense), .stat_oe_o(stat_oe),
        .stat_o(), .drive_o(drive), .mode_o(mode), .state_o(state));
    initial begin
        core_clk_i = 1'b0;
        forever #12.5 core_clk_i = ~core_clk_i;
    end
    task automatic supply(input logic [15:0] bus, input logic [15:0] bat, input logic [7:0] temp);
        @(posedge core_clk_i);
        vbus <= bus;
        vbat <= bat;
        die <= temp;
        repeat (8) @(posedge core_clk_i);
        #1;
    endtask
    task automatic test_qualify;
        supply(16'h1388, 16'h0ed8, 8'h19);
        `CHK(mode, lics_pkg::LICS_MODE_CHARGE)
        `CHK(state, lics_pkg::LICS_ST_QUALIFY)
        `CHK(drive.validation_load_on, 1'b1)
        limit_sel <= 1'b1;
        supply(16'h1388, 16'h0ed8, 8'h19);
        `CHK(drive.input_current_limit, lics_pkg::ILIM_MAX)
        limit_sel <= 1'b0;
        repeat (2000) @(posedge core_clk_i);
        #1;
        `CHK(drive.input_current_limit, lics_pkg::ILIM_LOW_SEL)
        `CHK(state, lics_pkg::LICS_ST_QUALIFY)
    endtask
    task automatic test_ovp;
        supply(16'h17d4, 16'h0ed8, 8'h19);
        `CHK(state, lics_pkg::LICS_ST_FAULT)
        `CHK(drive.blocking_switch_on, 1'b0)
        supply(16'h170c, 16'h0ed8, 8'h19);
        `CHK(state, lics_pkg::LICS_ST_FAULT)
        supply(16'h1388, 16'h0ed8, 8'h19);
        `CHK(state, lics_pkg::LICS_ST_QUALIFY)
    endtask
    task automatic test_thermal;
        supply(16'h1388, 16'h0ed8, 8'h96);
        `CHK(state, lics_pkg::LICS_ST_FAULT)
        supply(16'h1388, 16'h0ed8, 8'h82);
        `CHK(state, lics_pkg::LICS_ST_FAULT)
        supply(16'h1388, 16'h0ed8, 8'h6e);
        `CHK(state, lics_pkg::LICS_ST_QUALIFY)
    endtask
    task automatic test_sleep_uvlo;
        supply(16'h10fe, 16'h1130, 8'h19);
        `CHK(drive.high_side_body_switch, 1'b1)
        supply(16'h0fa0, 16'h0ed8, 8'h19);
        `CHK(drive.validation_load_on, 1'b0)
        `CHK(drive.switching_enable, 1'b0)
    endtask
    task automatic test_boost;
        supply(16'h0000, 16'h0ed8, 8'h19);
        boost_pin <= 1'b1;
        supply(16'h0000, 16'h0ed8, 8'h19);
        `CHK(mode, lics_pkg::LICS_MODE_BOOST)
        `CHK(drive.switching_enable, 1'b0)
        boost_pin <= 1'b0;
        supply(16'h0000, 16'h0ed8, 8'h19);
        `CHK(mode, lics_pkg::LICS_MODE_HIZ)
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // The tests need some 2,100 cycles; 20,000 leaves room without hiding a hang.
    initial begin
        #500000;
        errors++;
        give_verdict();
    end
    initial begin
        rst_n_i = 1'b0;
        boost_pin = 1'b0;
        limit_sel = 1'b0;
        vbus = 16'h0000;
        vbat = 16'h0ed8;
        die = 8'h19;
        repeat (2) @(posedge core_clk_i);
        #1;
        `CHK(mode, lics_pkg::LICS_MODE_HIZ)
        `CHK(stat_oe, 1'b0)
        `CHK(drive, lics_pkg::lics_drive_type'('0))
        @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        test_qualify();
        test_ovp();
        test_thermal();
        test_sleep_uvlo();
        test_boost();
        give_verdict();
    end
endmodule
